// file: src/buck_coin_pkg.sv
// Purpose: Shared constants for the buck and coin charger register bank
// Assumes: APB byte addresses, 8-bit registers in the low bits of a word
// Notes: Fuse presets arrive as inputs and are not constants here
package buck_coin_pkg;
	localparam int ADDR_W = 8;
	localparam int REG_W = 8;
	// Register indices as printed; byte address is four times the index
	localparam logic [7:0] IDX_SENSE = 8'h2a;
	localparam logic [7:0] IDX_COIN = 8'h30;
	localparam logic [7:0] IDX_RUN_VOLT = 8'h32;
	localparam logic [7:0] IDX_STBY_VOLT = 8'h33;
	localparam logic [7:0] IDX_SLP_VOLT = 8'h34;
	localparam logic [7:0] IDX_CTRL = 8'h35;
	localparam logic [7:0] IDX_MODE = 8'h3f;
	// Field layout
	localparam int COIN_CODE_W = 4;
	localparam int COIN_ON_BIT = 4;
	localparam int VCODE_W = 6;
	localparam int BIT_RUN_ON = 0;
	localparam int BIT_STBY_ON = 1;
	localparam int BIT_SLP_ON = 2;
	localparam int BIT_LPWR = 3;
	localparam int BIT_SLEW = 4;
	localparam int BIT_CCM_DN = 5;
	localparam int BIT_FORCED_PULSE_MODE = 6;
	localparam int BIT_RDIS_OFF = 7;
	localparam int SENSE_W = 5;
	localparam logic [3:0] COIN_CODE_RST = 4'h0;
	// Operating states as written to the mode register
	localparam logic [1:0] MODE_RUN = 2'h0;
	localparam logic [1:0] MODE_STBY = 2'h1;
	localparam logic [1:0] MODE_SLP = 2'h2;
endpackage

// file: src/buck_coin_regs.sv
// Purpose: APB register bank for one buck channel and the coin charger
// Assumes: Fuse values are stable while presetn is low and just after
// Notes: Zero-wait APB slave; pslverr flags unmapped addresses or writes to the sense register
//
// The APB register port was left to the implementer.
`timescale 1ns/1ps

// Functional notes
// - The coin charge voltage code is four bits and resets to zero.
// - The charger enable bit resets to zero so the charger starts off.
// - The run voltage code is six bits, preset from fuses at reset.
// - The standby voltage code is six bits, preset to the run preset.
// - The sleep voltage code is six bits, preset to the run preset.
// - Control bit zero enables run mode, preset from the fuse sequence.
// - Control bit one enables standby, preset to the fused run enable.
// - Control bit two enables sleep and resets to zero.
// - Control bit three selects low power in standby or sleep.
// - Control bit four picks slow slew unless the fused select is one.
// - Control bit five forces continuous conduction while ramping down.
// - Control bit six forces continuous conduction at all loads.
// - Control bit seven low connects the discharge resistor when off.
// - Fuse-loaded fields preset at power-up and stay read-write.
module buck_coin_regs #(
	parameter int PADDR_W = 10
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [PADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [5:0] fused_run_code,
	input wire logic fused_run_on,
	input wire logic fused_slew,
	input wire logic fused_scaling_select,
	input wire logic [4:0] sense_in,
	output logic [3:0] charge_voltage_code,
	output logic charger_on,
	output logic [5:0] active_voltage_code,
	output logic regulator_on,
	output logic low_power_active,
	output logic slow_slew,
	output logic continuous_during_ramp_down,
	output logic force_continuous_conduction,
	output logic discharge_active
);

	// Elaboration checks: the bus must reach the top register index and fit 32 bits
	if (PADDR_W < 10) begin : g_chk_addr_min
		$error("PADDR_W too small for the register map");
	end
	if (PADDR_W > 32) begin : g_chk_addr_max
		$error("PADDR_W wider than an APB address");
	end

	// Elaboration checks: field layout the decode relies on
	if (buck_coin_pkg::REG_W != 8) begin : g_chk_reg_w
		$error("Register width must be eight bits");
	end
	if (buck_coin_pkg::ADDR_W != 8) begin : g_chk_idx_w
		$error("Register index must be eight bits");
	end
	if (buck_coin_pkg::COIN_CODE_W != 4) begin : g_chk_coin_w
		$error("Coin voltage code must be four bits");
	end
	if (buck_coin_pkg::COIN_ON_BIT != buck_coin_pkg::COIN_CODE_W) begin : g_chk_on
		$error("Charger enable must sit just above the code");
	end
	if (buck_coin_pkg::VCODE_W != 6) begin : g_chk_vcode_w
		$error("Voltage codes must be six bits");
	end
	if (buck_coin_pkg::SENSE_W != 5) begin : g_chk_sense_w
		$error("Sense field must be five bits");
	end
	if (buck_coin_pkg::BIT_RDIS_OFF >= buck_coin_pkg::REG_W) begin : g_chk_top
		$error("Control bits must fit one register");
	end
	if (buck_coin_pkg::MODE_SLP == buck_coin_pkg::MODE_STBY) begin : g_chk_mode
		$error("Operating state codes must differ");
	end

	typedef struct packed {
		logic loaded;
		logic [3:0] coin_code;
		logic coin_on;
		logic [5:0] run_code;
		logic [5:0] stby_code;
		logic [5:0] slp_code;
		logic [7:0] ctrl;
		logic [1:0] mode;
		logic [31:0] rdata;
		logic ready;
		logic err;
		logic [3:0] o_coin_code;
		logic o_coin_on;
		logic [5:0] o_code;
		logic o_on;
		logic o_lpwr;
		logic o_slow;
		logic o_ccm_dn;
		logic o_forced_pulse_mode;
		logic o_dis;
	} state_t;

	state_t st_ff;
	state_t nxt_st;
	logic [7:0] idx;
	logic setup;
	logic wr_ok;
	logic [7:0] wb;
	logic [7:0] rd_byte;
	logic hit;
	logic [1:0] mode_now;
	logic [7:0] ctrl_now;
	logic [4:0] sense_q;

	// Word index from the byte address
	assign idx = paddr[9:2];
	assign setup = psel && !penable;
	assign wb = pwdata[7:0];
	assign wr_ok = setup && pwrite && pstrb[0];

	// One select per mapped register
	logic sel_sense;
	logic sel_coin;
	logic sel_run;
	logic sel_stby;
	logic sel_slp;
	logic sel_ctrl;
	logic sel_mode;
	assign sel_sense = idx == buck_coin_pkg::IDX_SENSE;
	assign sel_coin = idx == buck_coin_pkg::IDX_COIN;
	assign sel_run = idx == buck_coin_pkg::IDX_RUN_VOLT;
	assign sel_stby = idx == buck_coin_pkg::IDX_STBY_VOLT;
	assign sel_slp = idx == buck_coin_pkg::IDX_SLP_VOLT;
	assign sel_ctrl = idx == buck_coin_pkg::IDX_CTRL;
	assign sel_mode = idx == buck_coin_pkg::IDX_MODE;

	// Sense levels come from another domain
	sense_sync #(
		.W(buck_coin_pkg::SENSE_W)
	) u_sense_sync (
		.pclk(pclk),
		.presetn(presetn),
		.clk_en(clk_en),
		.d(sense_in),
		.q(sense_q)
	);

	// Read mux and address decode
	always_comb begin
		rd_byte = 8'h00;
		hit = 1'b1;
		unique case (idx)
			buck_coin_pkg::IDX_SENSE:
				rd_byte = {3'h0, sense_q};
			buck_coin_pkg::IDX_COIN:
				rd_byte = {3'h0, st_ff.coin_on, st_ff.coin_code};
			buck_coin_pkg::IDX_RUN_VOLT:
				rd_byte = {2'h0, st_ff.run_code};
			buck_coin_pkg::IDX_STBY_VOLT:
				rd_byte = {2'h0, st_ff.stby_code};
			buck_coin_pkg::IDX_SLP_VOLT:
				rd_byte = {2'h0, st_ff.slp_code};
			buck_coin_pkg::IDX_CTRL:
				rd_byte = st_ff.ctrl;
			buck_coin_pkg::IDX_MODE:
				rd_byte = {6'h00, st_ff.mode};
			default:
				hit = 1'b0;
		endcase
	end

	// Next state: fuse load, register writes, output selection
	always_comb begin
		nxt_st = st_ff;
		// Answer lasts one cycle unless a setup is taken
		nxt_st.ready = 1'b0;
		nxt_st.err = 1'b0;
		if (!st_ff.loaded) begin
			nxt_st.loaded = 1'b1;
			nxt_st.run_code = fused_run_code;
			nxt_st.stby_code = fused_run_code;
			nxt_st.slp_code = fused_run_code;
			nxt_st.ctrl = 8'h00;
			nxt_st.ctrl[buck_coin_pkg::BIT_RUN_ON] = fused_run_on;
			nxt_st.ctrl[buck_coin_pkg::BIT_STBY_ON] = fused_run_on;
			nxt_st.ctrl[buck_coin_pkg::BIT_SLEW] = fused_slew;
		end else if (setup) begin
			// Answer the setup in the following cycle
			nxt_st.ready = 1'b1;
			nxt_st.err = !hit || (pwrite && sel_sense);
			if (pwrite) begin
				nxt_st.rdata = 32'h0;
			end else begin
				nxt_st.rdata = {24'h0, rd_byte};
			end
			// Writes land only with the low byte strobe set
			if (wr_ok && sel_coin) begin
				nxt_st.coin_code = wb[buck_coin_pkg::COIN_CODE_W-1:0];
				nxt_st.coin_on = wb[buck_coin_pkg::COIN_ON_BIT];
			end
			if (wr_ok && sel_run) begin
				nxt_st.run_code = wb[buck_coin_pkg::VCODE_W-1:0];
			end
			if (wr_ok && sel_stby) begin
				nxt_st.stby_code = wb[buck_coin_pkg::VCODE_W-1:0];
			end
			if (wr_ok && sel_slp) begin
				nxt_st.slp_code = wb[buck_coin_pkg::VCODE_W-1:0];
			end
			if (wr_ok && sel_ctrl) begin
				nxt_st.ctrl = wb;
			end
			// Unused state code leaves the mode as it was
			if (wr_ok && sel_mode && wb[1:0] != 2'h3) begin
				nxt_st.mode = wb[1:0];
			end
		end

		// Values seen after this edge
		mode_now = nxt_st.mode;
		ctrl_now = nxt_st.ctrl;
		// Apply the set that belongs to the operating state
		unique case (mode_now)
			buck_coin_pkg::MODE_STBY: begin
				nxt_st.o_code = nxt_st.stby_code;
				nxt_st.o_on = ctrl_now[buck_coin_pkg::BIT_STBY_ON];
			end
			buck_coin_pkg::MODE_SLP: begin
				nxt_st.o_code = nxt_st.slp_code;
				nxt_st.o_on = ctrl_now[buck_coin_pkg::BIT_SLP_ON];
			end
			default: begin
				nxt_st.o_code = nxt_st.run_code;
				nxt_st.o_on = ctrl_now[buck_coin_pkg::BIT_RUN_ON];
			end
		endcase
		nxt_st.o_lpwr = ctrl_now[buck_coin_pkg::BIT_LPWR] &&
			mode_now != buck_coin_pkg::MODE_RUN;
		nxt_st.o_slow = ctrl_now[buck_coin_pkg::BIT_SLEW] &&
			!fused_scaling_select;
		nxt_st.o_ccm_dn = ctrl_now[buck_coin_pkg::BIT_CCM_DN];
		nxt_st.o_forced_pulse_mode = ctrl_now[buck_coin_pkg::BIT_FORCED_PULSE_MODE];
		nxt_st.o_dis = !ctrl_now[buck_coin_pkg::BIT_RDIS_OFF] &&
			!nxt_st.o_on;
		nxt_st.o_coin_code = nxt_st.coin_code;
		nxt_st.o_coin_on = nxt_st.coin_on;
	end

	// State register, constants only under reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_ff <= '0;
			st_ff.coin_code <= buck_coin_pkg::COIN_CODE_RST;
			st_ff.mode <= buck_coin_pkg::MODE_RUN;
			st_ff.o_dis <= 1'b1;
		end else if (clk_en) begin
			st_ff <= nxt_st;
		end
	end

	// Bus answer straight from flip-flops
	assign prdata = st_ff.rdata;
	assign pready = st_ff.ready;
	assign pslverr = st_ff.err;

	// Charger and regulator controls straight from flip-flops
	assign charge_voltage_code = st_ff.o_coin_code;
	assign charger_on = st_ff.o_coin_on;
	assign active_voltage_code = st_ff.o_code;
	assign regulator_on = st_ff.o_on;
	assign low_power_active = st_ff.o_lpwr;
	assign slow_slew = st_ff.o_slow;
	assign continuous_during_ramp_down = st_ff.o_ccm_dn;
	assign force_continuous_conduction = st_ff.o_forced_pulse_mode;
	assign discharge_active = st_ff.o_dis;

endmodule

// Two-flop synchroniser for asynchronous level inputs
module sense_sync #(
	parameter int W = 5
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);

	// Refuse an empty bus
	if (W < 1) begin : g_chk_w
		$error("W must be at least one");
	end

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} sync_t;

	sync_t sy_ff;
	sync_t nxt_sy;

	// First stage feeds only the second
	always_comb begin
		nxt_sy.s1 = d;
		nxt_sy.s2 = sy_ff.s1;
	end

	// Stages clear under reset and hold when disabled
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sy_ff <= '0;
		end else if (clk_en) begin
			sy_ff <= nxt_sy;
		end
	end

	// Only the second stage leaves
	assign q = sy_ff.s2;

endmodule

// file: tb/buck_coin_props.sv
// Purpose: Port checks for the buck and coin register bank
// Assumes: Bus stays idle on the first edge after reset
// Notes: Bound to every bank instance
`timescale 1ns/1ps
module buck_coin_props (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [9:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [3:0] charge_voltage_code,
	input wire logic charger_on,
	input wire logic regulator_on,
	input wire logic discharge_active
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Setup phase taken by the slave
	sequence s_setup;
		psel && !penable && clk_en;
	endsequence
	AST_ANSWER: assert property (s_setup |=> pready ##1 !pready)
		else $error("answer not one cycle");
	AST_ERR_PAIR: assert property (pslverr |-> pready)
		else $error("error without ready");
	AST_UNMAPPED: assert property (
		s_setup ##0 paddr[9:2] == 8'h00 |=> pslverr) else $error("no error");
	AST_UPPER: assert property (pready |-> prdata[31:8] == 24'h0)
		else $error("upper read bits set");
	AST_COIN_WR: assert property (
		s_setup ##0 pwrite && pstrb[0] && paddr[9:2] == 8'h30 |=>
		charge_voltage_code == pwdata[3:0] && charger_on == pwdata[4])
		else $error("coin write lost");
	AST_COIN_RST: assert property (
		$rose(presetn) |-> charge_voltage_code == 4'h0 && !charger_on)
		else $error("coin reset value");
	AST_DISCH: assert property (regulator_on |-> !discharge_active)
		else $error("discharge while on");
	AST_QUIET: assert property ($rose(presetn) |-> !pready ##1 !pready)
		else $error("answer after reset");
endmodule
bind buck_coin_regs buck_coin_props chk (.*);

// file: tb/apb_host.sv
// Purpose: Host side model issuing register transfers
// Assumes: The bench watchdog cuts a slave that never answers
// Notes: Address and data are inverted once the bus is released
`timescale 1ns/1ps
module apb_host (
	input wire logic pclk,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [9:0] paddr,
	output logic [31:0] pwdata,
	output logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	initial {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
	// Setup, access until ready, then release
	task xfer(input logic w, input logic [9:0] a, input logic [31:0] d,
		input logic [3:0] s, output logic [31:0] r, output logic e);
		@(posedge pclk);
		{psel, pwrite, paddr, pwdata, pstrb} <= {1'b1, w, a, d, s};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		{r, e} = {prdata, pslverr};
		{psel, penable} <= 2'h0;
		{paddr, pwdata} <= ~{a, d};
	endtask
endmodule

// file: tb/buck_coin_regs_tb.sv
// Purpose: Self-checking bench for the buck and coin register bank
// Assumes: Fuse inputs change only while reset is held
// Notes: Register model is an int array indexed by register
`timescale 1ns/1ps
module buck_coin_regs_tb;
	logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr;
	logic fused_run_on, fused_slew, fused_scaling_select, charger_on, er;
	logic regulator_on, low_power_active, slow_slew, discharge_active;
	logic continuous_during_ramp_down, force_continuous_conduction;
	logic [9:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] pstrb, charge_voltage_code;
	logic [5:0] fused_run_code, active_voltage_code;
	logic [4:0] sense_in;
	int error_cnt, comparisons, v, k, m[256];
	int idx[8] = '{0, 8'h2a, 8'h30, 8'h32, 8'h33, 8'h34, 8'h35, 8'h3f};
	int mk[8] = '{255, 0, 31, 63, 63, 63, 255, 3};
	wire [5:0] ctl = {force_continuous_conduction, continuous_during_ramp_down,
		slow_slew, low_power_active, regulator_on, discharge_active};
	buck_coin_regs DUT (.*);
	apb_host host (.*);
	task chk(input logic [31:0] s, input logic [31:0] e);
		comparisons++;
		if (s !== e) begin
			error_cnt++;
			$display("MISMATCH %0t seen %h exp %h", $time, s, e);
		end
	endtask
	task close_out;
		$display("mismatches %0d of %0d", error_cnt, comparisons);
		if (error_cnt == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// One access, model update, then every output against the model
	task acc(input int a, input bit w, input int d, input logic [3:0] s);
		bit ok;
		int c;
		int x;
		ok = a inside {8'h2a, 8'h30, [8'h32:8'h35], 8'h3f};
		host.xfer(w, 10'(a * 4), 32'(d), s, rd, er);
		chk(er, !ok || w && a == 8'h2a);
		if (!w)
			chk(rd, m[a]);
		else if (ok && s[0] && a != 8'h2a && (a != 8'h3f || d < 3))
			m[a] = d;
		#1;
		v = m[8'h3f];
		c = m[8'h35];
		chk(active_voltage_code, m[8'h32 + v]);
		chk({charger_on, charge_voltage_code}, m[8'h30]);
		x = {c[6:5], c[4] & !fused_scaling_select, c[3] && v, c[v],
			!c[7] && !c[v]};
		chk(ctl, x);
	endtask
	initial begin
		pclk = 0;
		forever #25 pclk = ~pclk;
	end
	initial begin
		#500000;
		error_cnt++;
		close_out;
	end
	initial begin
		v = $urandom(47);
		clk_en <= 1'b1;
		for (int r = 0; r < 2; r++) begin
			presetn <= 1'b0;
			{fused_run_code, fused_run_on, fused_slew, fused_scaling_select,
				sense_in} <= 14'($urandom);
			repeat (12) @(posedge pclk);
			presetn <= 1'b1;
			repeat (2) @(posedge pclk);
			// Reset and fuse preset values
			m = '{default: 0};
			m[8'h2a] = sense_in;
			for (k = 8'h32; k < 8'h35; k++) m[k] = fused_run_code;
			m[8'h35] = {fused_slew, 2'h0, fused_run_on, fused_run_on};
			foreach (idx[j]) acc(idx[j], 0, 0, 4'h0);
			// Random writes with strobes, each read back
			repeat (80) begin
				k = $urandom % 8;
				acc(idx[k], 1, $urandom & mk[k], 4'($urandom));
				acc(idx[k], 0, 0, 4'h0);
			end
			$display("reset round %0d done", r);
		end
		close_out;
	end
endmodule
